// [design/gpr_dev_end.sv]
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "gpr_map.svh"
module gpr_dev_end (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Link pins
    gpr_if.dev link,
    // Configuration
    input wire logic [7:0] pin_map_reg_a_i,
    input wire logic [7:0] pin_map_reg_b_i,
    input wire logic packet_mode_i,
    input wire gpr_pkg::gpr_mode_t op_mode_i,
    input wire logic bitsync_en_i,
    input wire logic length_format_sel_i,
    input wire logic [7:0] payload_len_cfg_i,
    input wire logic aes_en_i,
    input wire logic addr_en_i,
    // Internal status sources
    input wire logic supply_low_flag_i,
    input wire logic mode_settled_flag_i,
    input wire logic auto_sequence_active_i,
    input wire logic divided_ref_clock_out_i,
    input wire logic synth_locked_flag_i,
    input wire logic timeout_flag_i,
    input wire logic rssi_flag_i,
    input wire logic sync_match_flag_i,
    input wire logic receiver_ready_flag_i,
    input wire logic transmitter_ready_flag_i,
    input wire logic queue_full_flag_i,
    input wire logic queue_nonempty_flag_i,
    input wire logic queue_threshold_flag_i,
    input wire logic check_good_flag_i,
    input wire logic payload_available_flag_i,
    input wire logic frame_done_flag_i,
    // Modem bit streams
    input wire logic demod_bit_i,
    input wire logic frame_bit_i,
    output logic mod_bit_o,
    // Datapath and format status
    output logic bitsync_on_o,
    output logic queue_path_o,
    output logic queue_spi_ok_o,
    output logic len_byte_o,
    output logic fmt_fixed_o,
    output logic fmt_variable_o,
    output logic fmt_unlimited_o,
    output logic len_ok_o
);
    import gpr_pkg::*;

    localparam logic [3:0] HALF_M1 = 4'(`GPR_HALF_CYC - 1);

    // ==========================================
    // Pin source table, row = {pin5 .. pin0}
    function automatic logic [29:0] pin_row(input logic pkt, input gpr_mode_t md,
                                            input logic [1:0] code);
        logic [29:0] r;
        unique case ({pkt, md, code})
            {1'b0, GPR_SLEEP, 2'd2}: r = {S_LB, S_LB, S_AM, S_LO, S_LO, S_LB};
            {1'b0, GPR_SLEEP, 2'd3}: r = {S_MR, S_LO, S_LO, S_LO, S_LO, S_MR};
            {1'b0, GPR_STDBY, 2'd0}: r = {S_CK, S_LO, S_LO, S_LO, S_LO, S_LO};
            {1'b0, GPR_STDBY, 2'd2}: r = {S_LB, S_LB, S_AM, S_LO, S_LO, S_LB};
            {1'b0, GPR_STDBY, 2'd3}: r = {S_MR, S_LO, S_LO, S_LO, S_LO, S_MR};
            {1'b0, GPR_SYNTH_ONLY, 2'd0}: r = {S_CK, S_LO, S_LO, S_LO, S_PL, S_PL};
            {1'b0, GPR_SYNTH_ONLY, 2'd1}: r = {S_LO, S_LO, S_LO, S_LO, S_PL, S_LO};
            {1'b0, GPR_SYNTH_ONLY, 2'd2}: r = {S_LB, S_LB, S_AM, S_LO, S_PL, S_LB};
            {1'b0, GPR_SYNTH_ONLY, 2'd3}: r = {S_MR, S_PL, S_LO, S_LO, S_PL, S_MR};
            {1'b0, GPR_RX, 2'd0}: r = {S_CK, S_TO, S_RS, S_DA, S_DC, S_SA};
            {1'b0, GPR_RX, 2'd1}: r = {S_RS, S_RR, S_RR, S_DA, S_RR, S_TO};
            {1'b0, GPR_RX, 2'd2}: r = {S_LB, S_SA, S_AM, S_DA, S_LB, S_RS};
            {1'b0, GPR_RX, 2'd3}: r = {S_MR, S_PL, S_TO, S_DA, S_SA, S_PL};
            {1'b0, GPR_TX, 2'd0}: r = {S_CK, S_TR, S_LB, S_DA, S_DC, S_PL};
            {1'b0, GPR_TX, 2'd1}: r = {S_CK, S_TR, S_LB, S_DA, S_TR, S_PL};
            {1'b0, GPR_TX, 2'd2}: r = {S_LB, S_TR, S_AM, S_DA, S_LB, S_PL};
            {1'b0, GPR_TX, 2'd3}: r = {S_MR, S_PL, S_TR, S_DA, S_LB, S_PL};
            {1'b1, GPR_SLEEP, 2'd0}: r = {S_LO, S_LO, S_FF, S_FN, S_FL, S_LO};
            {1'b1, GPR_SLEEP, 2'd1}: r = {S_LO, S_LO, S_LO, S_LO, S_FF, S_LO};
            {1'b1, GPR_SLEEP, 2'd2}: r = {S_LB, S_LB, S_LO, S_LO, S_FN, S_LB};
            {1'b1, GPR_SLEEP, 2'd3}: r = {S_MR, S_MR, S_LO, S_AM, S_PL, S_MR};
            {1'b1, GPR_STDBY, 2'd0}: r = {S_CK, S_LO, S_FF, S_FN, S_FL, S_LO};
            {1'b1, GPR_STDBY, 2'd1}: r = {S_LO, S_LO, S_LO, S_LO, S_FF, S_LO};
            {1'b1, GPR_STDBY, 2'd2}: r = {S_LB, S_LB, S_LO, S_LO, S_FN, S_LB};
            {1'b1, GPR_STDBY, 2'd3}: r = {S_MR, S_MR, S_LO, S_AM, S_TO, S_MR};
            {1'b1, GPR_SYNTH_ONLY, 2'd0}: r = {S_CK, S_LO, S_FF, S_FN, S_FL, S_PL};
            {1'b1, GPR_SYNTH_ONLY, 2'd1}: r = {S_LO, S_LO, S_LO, S_LO, S_FF, S_LO};
            {1'b1, GPR_SYNTH_ONLY, 2'd2}: r = {S_LB, S_LB, S_LO, S_LO, S_FN, S_LB};
            {1'b1, GPR_SYNTH_ONLY, 2'd3}: r = {S_MR, S_PL, S_LO, S_AM, S_PL, S_MR};
            {1'b1, GPR_RX, 2'd0}: r = {S_CK, S_TO, S_FF, S_FN, S_FL, S_CR};
            {1'b1, GPR_RX, 2'd1}: r = {S_DA, S_RS, S_RS, S_DA, S_FF, S_PR};
            {1'b1, GPR_RX, 2'd2}: r = {S_LB, S_RR, S_SA, S_LB, S_FN, S_SA};
            {1'b1, GPR_RX, 2'd3}: r = {S_MR, S_PL, S_PL, S_AM, S_TO, S_RS};
            {1'b1, GPR_TX, 2'd0}: r = {S_CK, S_MR, S_FF, S_FN, S_FL, S_PS};
            {1'b1, GPR_TX, 2'd1}: r = {S_DA, S_TR, S_TR, S_DA, S_FF, S_TR};
            {1'b1, GPR_TX, 2'd2}: r = {S_LB, S_LB, S_LB, S_LB, S_FN, S_LB};
            {1'b1, GPR_TX, 2'd3}: r = {S_MR, S_PL, S_PL, S_AM, S_PL, S_PL};
            default: r = {6{S_LO}}; // Unassigned and illegal codes stay low
        endcase
        return r;
    endfunction : pin_row

    logic is_rx, is_tx, cont, bs_eff, data_in_s;
    logic [3:0] div_q;
    logic dclk_q, dclk_rise, dclk_fall;
    logic tx_bit_q, rx_bit_q, rx_data, data_val;
    logic rr_prev_q, pr_prev_q, gate_q;
    logic [5:0] pin_q;
    logic data_oe_n_q;
    logic [18:0] src_v;
    logic [`GPR_MAP_W-1:0] codes;

    assign is_rx = (op_mode_i == GPR_RX);
    assign is_tx = (op_mode_i == GPR_TX);
    assign cont = ~packet_mode_i;
    assign bs_eff = packet_mode_i | bitsync_en_i; // Forced on for packets

    // ==========================================
    // Host data pin; it arrives from outside the clock
    gpr_sync2 #(.W(1)) u_data_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i(link.pin[`GPR_DATA_PIN]),
        .q_o(data_in_s)
    );

    // Bit clock divider, idle low outside receive and transmit
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= 4'h0;
            dclk_q <= 1'b0;
        end else if (ce_i) begin
            if (!(is_rx || is_tx)) begin
                div_q <= 4'h0;
                dclk_q <= 1'b0;
            end else if (div_q == HALF_M1) begin
                div_q <= 4'h0;
                dclk_q <= ~dclk_q;
            end else begin
                div_q <= div_q + 4'h1;
            end
        end
    end

    assign dclk_rise = (is_rx || is_tx) && (div_q == HALF_M1) && !dclk_q;
    assign dclk_fall = (is_rx || is_tx) && (div_q == HALF_M1) && dclk_q;

    // Transmit bit taken once per clock, at its rising edge
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            tx_bit_q <= 1'b0;
        end else if (ce_i && cont && is_tx && dclk_rise) begin
            tx_bit_q <= data_in_s; // Host is stable here
        end
    end

    // Cleaned receive bit moves on the falling edge only
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rx_bit_q <= 1'b0;
        end else if (ce_i && dclk_fall) begin
            rx_bit_q <= demod_bit_i; // Valid a half period before rise
        end
    end

    // Receive data window opens and closes on ready edges
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rr_prev_q <= 1'b0;
            pr_prev_q <= 1'b0;
            gate_q <= 1'b0;
        end else if (ce_i) begin
            rr_prev_q <= receiver_ready_flag_i;
            pr_prev_q <= payload_available_flag_i;
            if (payload_available_flag_i && !pr_prev_q) begin
                gate_q <= 1'b0; // Closing edge wins a tie
            end else if (receiver_ready_flag_i && !rr_prev_q) begin
                gate_q <= 1'b1;
            end
        end
    end

    // Raw or cleaned bit, and the data source per mode
    assign rx_data = bs_eff ? rx_bit_q : demod_bit_i;
    assign data_val = packet_mode_i ? (is_tx ? frame_bit_i : (gate_q & rx_data)) : rx_data;

    // ==========================================
    // Source vector indexed by the source type
    always_comb begin
        src_v = '0;
        src_v[S_LB] = supply_low_flag_i;
        src_v[S_MR] = mode_settled_flag_i;
        src_v[S_AM] = auto_sequence_active_i;
        src_v[S_CK] = divided_ref_clock_out_i;
        src_v[S_PL] = synth_locked_flag_i;
        src_v[S_TO] = timeout_flag_i;
        src_v[S_RS] = rssi_flag_i;
        src_v[S_DA] = data_val;
        src_v[S_DC] = dclk_q & cont & ((is_rx & bs_eff) | is_tx); // None if raw
        src_v[S_SA] = sync_match_flag_i;
        src_v[S_RR] = receiver_ready_flag_i;
        src_v[S_TR] = transmitter_ready_flag_i;
        src_v[S_FF] = queue_full_flag_i;
        src_v[S_FN] = queue_nonempty_flag_i;
        src_v[S_FL] = queue_threshold_flag_i;
        src_v[S_CR] = check_good_flag_i;
        src_v[S_PR] = payload_available_flag_i;
        src_v[S_PS] = frame_done_flag_i;
    end

    // Codes of pins 0..5 from the two map registers
    assign codes = {pin_map_reg_a_i, pin_map_reg_b_i[7:4]};

    // One selector per pin, each steered by its own code
    for (genvar k = 0; k < `GPR_PIN_N; k++) begin : g_pin
        logic [29:0] row;
        gpr_src_t sel;
        assign row = pin_row(packet_mode_i, op_mode_i, codes[`GPR_MAP_W-1-2*k -: 2]);
        assign sel = gpr_src_t'(row[k*`GPR_SRC_W +: `GPR_SRC_W]);
        always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
                pin_q[k] <= 1'b0;
            end else if (ce_i) begin
                pin_q[k] <= src_v[sel];
            end
        end
    end

    // Data pin turns round to the host in continuous transmit
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            data_oe_n_q <= 1'b0;
        end else if (ce_i) begin
            data_oe_n_q <= cont & is_tx;
        end
    end

    assign link.dev_pin = pin_q;
    assign link.dev_pin_oe_n = {3'h0, data_oe_n_q, 2'h0};

    // ==========================================
    // Datapath selection and packet format decode
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mod_bit_o <= 1'b0;
            bitsync_on_o <= 1'b0;
            queue_path_o <= 1'b0;
            queue_spi_ok_o <= 1'b0;
        end else if (ce_i) begin
            mod_bit_o <= packet_mode_i ? frame_bit_i : tx_bit_q;
            bitsync_on_o <= bs_eff;
            queue_path_o <= packet_mode_i; // Handler owns the frame
            queue_spi_ok_o <= packet_mode_i; // Any mode, sleep included
        end
    end

    // Format select and payload length limits
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            fmt_fixed_o <= 1'b0;
            fmt_variable_o <= 1'b0;
            fmt_unlimited_o <= 1'b0;
            len_byte_o <= 1'b0;
            len_ok_o <= 1'b0;
        end else if (ce_i) begin
            fmt_fixed_o <= !length_format_sel_i && (payload_len_cfg_i != 8'h00);
            fmt_variable_o <= length_format_sel_i;
            fmt_unlimited_o <= !length_format_sel_i && (payload_len_cfg_i == 8'h00);
            len_byte_o <= length_format_sel_i; // Sits after sync word
            // Eight bits already cap at 255; cipher caps the message
            len_ok_o <= !aes_en_i
                        || !(!length_format_sel_i && payload_len_cfg_i == 8'h00)
                        && (payload_len_cfg_i <= `GPR_AES_MSG_MAX + {7'h00, addr_en_i});
        end
    end
endmodule : gpr_dev_end
`default_nettype wire

// [design/gpr_map.svh]
`ifndef GPR_MAP_SVH
`define GPR_MAP_SVH

// ==========================================
// Timing
`define GPR_CLK_NS 20
`define GPR_BIT_NS 320
`define GPR_HALF_CYC ((`GPR_BIT_NS / 2) / `GPR_CLK_NS)

// ==========================================
// Pin map layout
`define GPR_PIN_N 6
`define GPR_SRC_W 5
`define GPR_MAP_W 12
`define GPR_DATA_PIN 2
`define GPR_DCLK_PIN 1

// ==========================================
// Packet format limits
`define GPR_AES_MSG_MAX 8'h40
`define GPR_LEN_MIN_VAR 8'h01

// ==========================================
// Host register map
`define GPR_REG_CTRL 8'h00
`define GPR_REG_TXDATA 8'h04
`define GPR_REG_RXDATA 8'h08
`define GPR_REG_PINS 8'h0c
`define GPR_REG_FMT 8'h10
`define GPR_CTRL_RST 3'h4
`define GPR_FMT_RST 11'h001
`define GPR_TXDATA_RST 8'h00
`define GPR_CTRL_DRIVE 0
`define GPR_CTRL_RXEN 1
`define GPR_CTRL_BSYNC 2
`define GPR_FMT_SEL 8
`define GPR_FMT_AES 9
`define GPR_FMT_ADDR 10

`endif

// [design/gpr_pkg.sv]
package gpr_pkg;
    // ==========================================
    // Operating modes
    typedef enum logic [2:0] {GPR_SLEEP, GPR_STDBY, GPR_SYNTH_ONLY, GPR_RX, GPR_TX} gpr_mode_t;
    // Signal sources a pin can carry
    typedef enum logic [4:0] {
        S_LO, S_LB, S_MR, S_AM, S_CK, S_PL, S_TO, S_RS, S_DA, S_DC,
        S_SA, S_RR, S_TR, S_FF, S_FN, S_FL, S_CR, S_PR, S_PS
    } gpr_src_t;
endpackage : gpr_pkg

// [design/gpr_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface gpr_if;
    // Device side drive and enables (enable low = driving)
    logic [5:0] dev_pin;
    logic [5:0] dev_pin_oe_n;
    // Host drive of the data pin
    logic host_data;
    logic host_data_oe_n;
    // Resolved pin levels; undriven pins read low
    logic [5:0] pin;

    assign pin = (dev_pin & ~dev_pin_oe_n) | {3'h0, host_data & ~host_data_oe_n, 2'h0};

    modport dev (output dev_pin, output dev_pin_oe_n, input pin);
    modport host (output host_data, output host_data_oe_n, input pin);
endinterface : gpr_if
`default_nettype wire

// [design/gpr_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module gpr_sync2 #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // ==========================================
    // Two stages; only the second is read outside
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : gpr_sync2
`default_nettype wire

// [design/gpr_host_end.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpr_map.svh"
module gpr_host_end (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Link pins
    gpr_if.host link,
    // Settings handed to the device
    output logic bitsync_req_o,
    output logic length_format_sel_o,
    output logic [7:0] payload_len_cfg_o,
    output logic aes_en_o,
    output logic addr_en_o
);
    import gpr_pkg::*;

    logic [5:0] pins_s;
    logic [2:0] ctrl_q;
    logic [10:0] fmt_q, fmt_w;
    logic [7:0] tx_byte_q, tx_sh_q, rx_sh_q, rx_byte_q, rx_cnt_q, cap;
    logic [2:0] rx_bits_q;
    logic dclk_prev_q, dclk_rise, dclk_fall, data_q, oe_n_q;
    logic setup, wr, mapped;
    logic [31:0] rd_val;

    // ==========================================
    // Pins arrive from the device's domain
    gpr_sync2 #(.W(`GPR_PIN_N)) u_pin_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i(link.pin),
        .q_o(pins_s)
    );

    // Edges of the device's data clock
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            dclk_prev_q <= 1'b0;
        end else if (ce_i) begin
            dclk_prev_q <= pins_s[`GPR_DCLK_PIN];
        end
    end

    assign dclk_rise = pins_s[`GPR_DCLK_PIN] & ~dclk_prev_q;
    assign dclk_fall = ~pins_s[`GPR_DCLK_PIN] & dclk_prev_q;

    // ==========================================
    // APB decode; one access cycle per transfer
    assign setup = psel_i & ~penable_i;
    assign wr = psel_i & penable_i & pwrite_i & pready_o;
    assign mapped = (paddr_i == `GPR_REG_CTRL) || (paddr_i == `GPR_REG_TXDATA)
                    || (paddr_i == `GPR_REG_RXDATA) || (paddr_i == `GPR_REG_PINS)
                    || (paddr_i == `GPR_REG_FMT);

    always_comb begin
        unique case (paddr_i)
            `GPR_REG_CTRL: rd_val = {29'h0, ctrl_q};
            `GPR_REG_TXDATA: rd_val = {24'h00_0000, tx_byte_q};
            `GPR_REG_RXDATA: rd_val = {16'h0000, rx_cnt_q, rx_byte_q};
            `GPR_REG_PINS: rd_val = {26'h0, pins_s};
            `GPR_REG_FMT: rd_val = {21'h0, fmt_q};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Answer staged in the setup cycle, so it comes from flops
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_o <= setup;
            pslverr_o <= setup & ~mapped;
            if (setup) begin
                prdata_o <= rd_val;
            end
        end
    end

    // Length clamps: variable needs a byte, cipher caps message
    assign cap = `GPR_AES_MSG_MAX + {7'h00, pwdata_i[`GPR_FMT_ADDR]};
    always_comb begin
        fmt_w = pwdata_i[10:0];
        if (pwdata_i[`GPR_FMT_SEL] && pwdata_i[7:0] < `GPR_LEN_MIN_VAR) begin
            fmt_w[7:0] = `GPR_LEN_MIN_VAR;
        end
        if (pwdata_i[`GPR_FMT_AES] && fmt_w[7:0] > cap) begin
            fmt_w[7:0] = cap;
        end
    end

    // Control and format registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= `GPR_CTRL_RST; // Synchroniser wanted from the start
            fmt_q <= `GPR_FMT_RST; // One-byte fixed payload
            tx_byte_q <= `GPR_TXDATA_RST;
        end else if (ce_i && wr && !pslverr_o) begin
            if (paddr_i == `GPR_REG_CTRL) begin
                ctrl_q <= pwdata_i[2:0];
            end
            if (paddr_i == `GPR_REG_FMT) begin
                fmt_q <= fmt_w; // Zero length here means unlimited
            end
            if (paddr_i == `GPR_REG_TXDATA) begin
                tx_byte_q <= pwdata_i[7:0];
            end
        end
    end

    // ==========================================
    // Transmit: change only after a falling edge, far from rise
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            tx_sh_q <= `GPR_TXDATA_RST;
            data_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (ce_i) begin
            oe_n_q <= ~ctrl_q[`GPR_CTRL_DRIVE];
            if (wr && paddr_i == `GPR_REG_TXDATA) begin
                tx_sh_q <= pwdata_i[7:0];
            end else if (dclk_fall && ctrl_q[`GPR_CTRL_DRIVE]) begin
                data_q <= tx_sh_q[7]; // Timed to the clock
                tx_sh_q <= {tx_sh_q[6:0], tx_sh_q[7]};
            end
        end
    end

    assign link.host_data = data_q;
    assign link.host_data_oe_n = oe_n_q;

    // Receive: take a bit on each rising edge, MSB first
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rx_sh_q <= 8'h00;
            rx_bits_q <= 3'h0;
            rx_byte_q <= 8'h00;
            rx_cnt_q <= 8'h00;
        end else if (ce_i && dclk_rise && ctrl_q[`GPR_CTRL_RXEN]) begin
            rx_sh_q <= {rx_sh_q[6:0], pins_s[`GPR_DATA_PIN]};
            rx_bits_q <= rx_bits_q + 3'h1;
            if (rx_bits_q == 3'h7) begin
                rx_byte_q <= {rx_sh_q[6:0], pins_s[`GPR_DATA_PIN]};
                rx_cnt_q <= rx_cnt_q + 8'h01;
            end
        end
    end

    assign bitsync_req_o = ctrl_q[`GPR_CTRL_BSYNC];
    assign length_format_sel_o = fmt_q[`GPR_FMT_SEL];
    assign payload_len_cfg_o = fmt_q[7:0];
    assign aes_en_o = fmt_q[`GPR_FMT_AES];
    assign addr_en_o = fmt_q[`GPR_FMT_ADDR];
endmodule : gpr_host_end
`default_nettype wire

// [dv/gpr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module gpr_monitor (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Link signals
    input wire logic [5:0] dev_pin,
    input wire logic [5:0] dev_pin_oe_n,
    input wire logic host_data,
    input wire logic host_data_oe_n,
    input wire logic [5:0] pin
);
    // ==========================================
    // Link checks; a released pin2 marks continuous transmit
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_oe; (dev_pin_oe_n & 6'h3b) == 6'h00; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_own; !host_data_oe_n |-> dev_pin_oe_n[2]; endproperty
    a_own: assert property (p_own) else $error("clash");
    property p_hi; $rose(pin[1]) && dev_pin_oe_n[2] |-> pin[1] [*8] ##1 !pin[1]; endproperty
    a_hi: assert property (p_hi) else $error("hi");
    property p_lo; $fell(pin[1]) && dev_pin_oe_n[2] |-> !pin[1] [*8] ##1 pin[1]; endproperty
    a_lo: assert property (p_lo) else $error("lo");
    property p_per; $rose(pin[1]) && dev_pin_oe_n[2] |-> ##16 $rose(pin[1]); endproperty
    a_per: assert property (p_per) else $error("per");
    property p_go; $rose(dev_pin_oe_n[2]) |-> !pin[1]; endproperty
    a_go: assert property (p_go) else $error("go");
    property p_hold; $rose(pin[1]) && !host_data_oe_n |-> $stable(host_data); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_chg; !host_data_oe_n && $changed(host_data) |-> !pin[1]; endproperty
    a_chg: assert property (p_chg) else $error("chg");
endmodule : gpr_monitor
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpr_pkg::*;
    logic clock_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0] paddr = 0, mapa = 0, mapb = 0, len;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] fl = 0;
    logic pm = 0, demod = 0, mb, bso, qp, qs, lb, ff, fv, fu, lok, bs, sel, aes, adr;
    logic [10:0] v, c;
    gpr_mode_t mode = GPR_SLEEP;
    int mismatches = 0, n_compared = 0;
    int rxi[4] = '{13, 14, 7, 6};
    int txi[4] = '{15, 9, 0, 4};
    gpr_if gpr_if_i ();
    gpr_dev_end gpr_dev_end_i (.clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1), .link(gpr_if_i),
        .pin_map_reg_a_i(mapa), .pin_map_reg_b_i(mapb), .packet_mode_i(pm), .op_mode_i(mode),
        .bitsync_en_i(bs), .length_format_sel_i(sel), .payload_len_cfg_i(len), .aes_en_i(aes),
        .addr_en_i(adr), .supply_low_flag_i(fl[0]), .mode_settled_flag_i(fl[1]),
        .auto_sequence_active_i(fl[2]), .divided_ref_clock_out_i(fl[3]),
        .synth_locked_flag_i(fl[4]), .timeout_flag_i(fl[5]), .rssi_flag_i(fl[6]),
        .sync_match_flag_i(fl[7]), .receiver_ready_flag_i(fl[8]),
        .transmitter_ready_flag_i(fl[9]), .queue_full_flag_i(fl[10]),
        .queue_nonempty_flag_i(fl[11]), .queue_threshold_flag_i(fl[12]),
        .check_good_flag_i(fl[13]), .payload_available_flag_i(fl[14]),
        .frame_done_flag_i(fl[15]), .demod_bit_i(demod), .frame_bit_i(fl[3]), .mod_bit_o(mb),
        .bitsync_on_o(bso), .queue_path_o(qp), .queue_spi_ok_o(qs), .len_byte_o(lb),
        .fmt_fixed_o(ff), .fmt_variable_o(fv), .fmt_unlimited_o(fu), .len_ok_o(lok));
    gpr_host_end gpr_host_end_i (.clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .link(gpr_if_i), .bitsync_req_o(bs), .length_format_sel_o(sel),
        .payload_len_cfg_o(len), .aes_en_o(aes), .addr_en_o(adr));
    gpr_monitor gpr_monitor_i (.clock_i(clock_i), .reset_i(reset_i),
        .dev_pin(gpr_if_i.dev_pin), .dev_pin_oe_n(gpr_if_i.dev_pin_oe_n),
        .host_data(gpr_if_i.host_data), .host_data_oe_n(gpr_if_i.host_data_oe_n),
        .pin(gpr_if_i.pin));
    // ==========================================
    // Bench tasks; APB answer taken at the edge that sees pready, one idle edge after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock_i);
        penable <= 1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clock_i);
    endtask : apb
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    function automatic logic [10:0] clamp(input logic [10:0] x);
        if (x[8] && x[7:0] == 8'h00) x[7:0] = 8'h01;
        if (x[9] && x[7:0] > 8'd64 + x[10]) x[7:0] = 8'd64 + x[10];
        return x;
    endfunction : clamp
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    // Clock, watchdog, then the tests
    initial forever #10 clock_i = ~clock_i;
    initial begin
        #200000 mismatches++;
        results();
    end
    initial begin
        void'($urandom(62));
        repeat (20) @(posedge clock_i);
        reset_i <= 0;
        @(posedge clock_i);
        apb(0, 8'h00, 0); chk("ctrl", rd, 32'h0000_0004);
        apb(0, 8'h10, 0); chk("fmt", rd, 32'h0000_0001);
        apb(1, 8'h20, 1); chk("err", er, 1);
        for (int k = 0; k < 10; k++) begin
            v = (k == 0) ? 11'h100 : (k == 1) ? 11'h000 : (k == 2) ? 11'h7ff : 11'($urandom);
            c = clamp(v);
            apb(1, 8'h10, {21'h0, v});
            apb(0, 8'h10, 0); chk("fmt", rd, {21'h0, c});
            chk("fix", ff, !c[8] && c[7:0] != 0);
            chk("var", fv, c[8]);
            chk("lenb", lb, c[8]);
            chk("unl", fu, !c[8] && c[7:0] == 0);
            chk("lok", lok, !c[9] || c[8] || c[7:0] != 0);
        end
        // Packet mode event pin with the synchroniser request off
        apb(1, 8'h00, 0);
        pm <= 1;
        // Packet receive data window; no ready edge has been seen yet
        mode <= GPR_RX;
        mapa <= 8'h04;
        demod <= 1'b1;
        repeat (40) @(posedge clock_i);
        chk("gate0", gpr_if_i.pin[2], 0);
        fl[8] <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("gate1", gpr_if_i.pin[2], 1);
        fl[14] <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("gate2", gpr_if_i.pin[2], 0);
        for (int k = 0; k < 8; k++) begin
            mode <= k[2] ? GPR_TX : GPR_RX;
            mapa <= {k[1:0], 6'h00};
            mapb <= 8'($urandom);
            fl <= 16'($urandom);
            repeat (3) @(posedge clock_i);
            chk("pin0", pin0(), fl[k[2] ? txi[k[1:0]] : rxi[k[1:0]]]);
            chk("bsync", bso, 1);
        end
        mode <= GPR_SLEEP;
        repeat (3) @(posedge clock_i);
        chk("qspi", qs, 1);
        pm <= 0; mode <= GPR_RX; mapa <= 0; mapb <= 0;
        repeat (8) begin
            demod <= 1'($urandom);
            repeat (3) @(posedge clock_i);
            chk("raw", gpr_if_i.pin[2], demod);
            chk("dclk", gpr_if_i.pin[1], 0);
        end
        chk("qpath", qp, 0);
        mode <= GPR_STDBY;
        @(posedge clock_i);
        mode <= GPR_TX;
        repeat (3) @(posedge clock_i);
        apb(1, 8'h04, 32'h0000_00ff);
        apb(1, 8'h00, 1);
        repeat (300) @(posedge clock_i);
        chk("mod1", mb, 1);
        apb(1, 8'h04, 32'h0000_0000);
        repeat (300) @(posedge clock_i);
        chk("mod0", mb, 0);
        results();
    end
    function automatic logic pin0();
        return gpr_if_i.pin[0];
    endfunction : pin0
endmodule : testbench
`default_nettype wire
